/* rtl/hbw_pkg.sv */
// Package with constants for the host bus width adapter.
package hbw_pkg;
  // ==========================================================================
  // Widths
  localparam int HBW_DATA_W   = 16;
  localparam int HBW_LANE_W   = 8;
  localparam int HBW_ADDR_W   = 13;
  localparam int HBW_WORD_A_W = 12;
  // ==========================================================================
  // Pin levels and reset values
  localparam logic       HBW_WIDTH_8      = 1'h0;
  localparam logic       HBW_WIDTH_16     = 1'h1;
  localparam logic [7:0] HBW_PULLUP_LANE  = 8'hFF;
  localparam logic [1:0] HBW_SYNC_ZERO    = 2'h0;
  localparam logic [2:0] HBW_SYNC3_ZERO   = 3'h0;
  // ==========================================================================
  // Lane masks for byte enables and lane drive, bit 0 the low lane
  localparam logic [1:0] HBW_LANES_NONE   = 2'h0;
  localparam logic [1:0] HBW_LANE_LOW     = 2'h1;
  localparam logic [1:0] HBW_LANE_HIGH    = 2'h2;
  localparam logic [1:0] HBW_LANES_BOTH   = 2'h3;
  // ==========================================================================
  // Access modes decoded from the byte address bit and the width strap
  typedef enum logic [1:0] {
    HBW_ACC_WORD    = 2'b00,
    HBW_ACC_EVEN    = 2'b01,
    HBW_ACC_ODD     = 2'b10,
    HBW_ACC_ILLEGAL = 2'b11
  } hbw_acc_e;
endpackage

/* rtl/hbw_sync3.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module hbw_sync3
  import hbw_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Asynchronous input and filtered level
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [2:0] chain;
    logic       level;
  } hbw_sync_s;

  hbw_sync_s st;
  hbw_sync_s next_st;

  // Only stages two and three feed the filter; the first stage is read by the second alone.
  always_comb begin
    next_st = st;
    next_st.chain = {st.chain[1:0], din};
    if (st.chain[1] == st.chain[2]) begin
      next_st.level = st.chain[2];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{chain: HBW_SYNC3_ZERO, level: 1'h0};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.level;
endmodule // hbw_sync3
`default_nettype wire

/* rtl/hbw_adapter.sv */
// Host bus width adapter: byte lane steering in front of a 16-bit internal store.
// How it works
// - Internal data path is 16 bits wide; byte access is the default mode.
// - In byte mode the upper data lane reads as pulled-up ones.
// - In byte mode odd or even address picks the matching byte lane.
// - Address bit low with strap high moves 16 bits; bit high is illegal.
// - Address bit low with strap low gives the even byte on the low lane.
// - Address bit high with strap low gives the odd byte on the low lane.
// - Strap negated selects byte mode, asserted selects word mode.
// - Only host address bits twelve to zero are decoded.
// - Lane zero is the least significant byte, lane one the most.
`timescale 1ns/100ps
`default_nettype none
module hbw_adapter
  import hbw_pkg::*;
#(
  parameter int ADDR_W = HBW_ADDR_W
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Width strap pin
  input  wire logic                        width_sel,
  // Host cycle, already on this clock
  input  wire logic                        host_rd,
  input  wire logic                        host_wr,
  input  wire logic [ADDR_W-1:0]           host_addr,
  input  wire logic [hbw_pkg::HBW_DATA_W-1:0] host_wdata,
  // Host data drive
  output logic [hbw_pkg::HBW_DATA_W-1:0]   host_rdata,
  output logic [1:0]                       host_rdata_oe,
  // Internal word store
  output logic [ADDR_W-2:0]                mem_addr,
  output logic                             mem_rd,
  output logic                             mem_wr,
  output logic [1:0]                       mem_byte_en,
  output logic [hbw_pkg::HBW_DATA_W-1:0]   mem_wdata,
  input  wire logic [hbw_pkg::HBW_DATA_W-1:0] mem_rdata,
  // Status
  output logic                             word_mode,
  output logic                             illegal_access
);
  import hbw_pkg::*;

  // ==========================================================================
  // Decode
  // The strap and the byte address bit together pick one of four access kinds.
  function automatic hbw_acc_e acc_decode(input logic a0, input logic wide_in);
    unique case ({a0, wide_in})
      {1'h0, HBW_WIDTH_16}: acc_decode = HBW_ACC_WORD;
      {1'h0, HBW_WIDTH_8}:  acc_decode = HBW_ACC_EVEN;
      {1'h1, HBW_WIDTH_8}:  acc_decode = HBW_ACC_ODD;
      default:              acc_decode = HBW_ACC_ILLEGAL;
    endcase
  endfunction

  function automatic logic acc_legal(input hbw_acc_e kind);
    acc_legal = (kind != HBW_ACC_ILLEGAL);
  endfunction

  // Bit zero only picks the byte; the higher host lines never reach this block.
  function automatic logic [ADDR_W-2:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = a[ADDR_W-1:1];
  endfunction

  // Byte enables of the internal word for a write of the given kind.
  function automatic logic [1:0] lane_enable(input hbw_acc_e kind);
    unique case (kind)
      HBW_ACC_WORD: lane_enable = HBW_LANES_BOTH;
      HBW_ACC_EVEN: lane_enable = HBW_LANE_LOW;
      HBW_ACC_ODD:  lane_enable = HBW_LANE_HIGH;
      default:      lane_enable = HBW_LANES_NONE;
    endcase
  endfunction

  // A byte write arrives on the low lane and is moved to the lane it belongs to.
  // The lane left out is filled, but its byte enable keeps it out of the store.
  function automatic logic [HBW_DATA_W-1:0] lane_place(input hbw_acc_e kind,
                                                       input logic [HBW_DATA_W-1:0] d);
    unique case (kind)
      HBW_ACC_WORD: lane_place = d;
      HBW_ACC_EVEN: lane_place = {HBW_PULLUP_LANE, d[HBW_LANE_W-1:0]};
      HBW_ACC_ODD:  lane_place = {d[HBW_LANE_W-1:0], HBW_PULLUP_LANE};
      default:      lane_place = {HBW_PULLUP_LANE, HBW_PULLUP_LANE};
    endcase
  endfunction

  // A byte read always leaves on the low lane; the high lane shows the pull-up level.
  function automatic logic [HBW_DATA_W-1:0] lane_pick(input hbw_acc_e kind,
                                                      input logic [HBW_DATA_W-1:0] d);
    unique case (kind)
      HBW_ACC_WORD: lane_pick = d;
      HBW_ACC_EVEN: lane_pick = {HBW_PULLUP_LANE, d[HBW_LANE_W-1:0]};
      HBW_ACC_ODD:  lane_pick = {HBW_PULLUP_LANE, d[HBW_DATA_W-1:HBW_LANE_W]};
      default:      lane_pick = {HBW_PULLUP_LANE, HBW_PULLUP_LANE};
    endcase
  endfunction

  // Lanes driven towards the host; the high lane is left to its pull-up in byte mode.
  function automatic logic [1:0] lane_drive(input hbw_acc_e kind);
    unique case (kind)
      HBW_ACC_WORD: lane_drive = HBW_LANES_BOTH;
      HBW_ACC_EVEN: lane_drive = HBW_LANE_LOW;
      HBW_ACC_ODD:  lane_drive = HBW_LANE_LOW;
      default:      lane_drive = HBW_LANES_NONE;
    endcase
  endfunction

  // ==========================================================================
  // State
  typedef struct packed {
    logic [HBW_DATA_W-1:0] rdata;
    logic [1:0]            oe;
    logic [ADDR_W-2:0]     maddr;
    logic                  mrd;
    logic                  mwr;
    logic [1:0]            ben;
    logic [HBW_DATA_W-1:0] wdata;
    logic                  rd_pend;
    hbw_acc_e              rd_acc;
    logic                  illegal;
  } hbw_adp_s;

  // Reset leaves both lanes undriven and the read register at the pull-up level.
  localparam hbw_adp_s ST_IDLE = '{
    rdata:   {HBW_PULLUP_LANE, HBW_PULLUP_LANE},
    oe:      HBW_LANES_NONE,
    maddr:   '0,
    mrd:     1'h0,
    mwr:     1'h0,
    ben:     HBW_LANES_NONE,
    wdata:   '0,
    rd_pend: 1'h0,
    rd_acc:  HBW_ACC_WORD,
    illegal: 1'h0
  };

  hbw_adp_s st;
  hbw_adp_s next_st;
  logic     wide;
  logic     byte_addr_bit;
  hbw_acc_e acc;

  // ==========================================================================
  // Strap filter
  // The strap is a pin, so it is filtered before it steers lanes.
  // A strap change needs four edges to arrive; it is meant to be tied, not toggled.
  hbw_sync3 u_width_sync (
    .clk   (clk),
    .reset (reset),
    .din   (width_sel),
    .dout  (wide)
  );

  assign byte_addr_bit = host_addr[0];
  assign acc           = acc_decode(byte_addr_bit, wide);

  // ==========================================================================
  // Steering
  always_comb begin
    next_st         = st;
    next_st.mrd     = 1'h0;
    next_st.mwr     = 1'h0;
    next_st.rd_pend = 1'h0;
    // The word address follows the host every cycle; the strobes alone qualify it.
    next_st.maddr   = word_addr(host_addr);
    if (host_rd || host_wr) begin
      next_st.illegal = !acc_legal(acc);
    end
    // A write wins when the host raises both strobes; a refused cycle never reaches the store.
    if (host_wr && acc_legal(acc)) begin
      next_st.mwr   = 1'h1;
      next_st.ben   = lane_enable(acc);
      next_st.wdata = lane_place(acc, host_wdata);
    end else if (host_rd && acc_legal(acc)) begin
      next_st.mrd     = 1'h1;
      next_st.ben     = HBW_LANES_BOTH;
      next_st.rd_pend = 1'h1;
      next_st.rd_acc  = acc;
    end
    // The store answers while its read strobe stands, so the lane is taken at the next edge.
    if (st.rd_pend) begin
      next_st.rdata = lane_pick(st.rd_acc, mem_rdata);
      next_st.oe    = lane_drive(st.rd_acc);
    end else if (!host_rd) begin
      next_st.oe = HBW_LANES_NONE;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // Host side.
  assign host_rdata     = st.rdata;
  assign host_rdata_oe  = st.oe;

  // Store side.
  assign mem_addr       = st.maddr;
  assign mem_rd         = st.mrd;
  assign mem_wr         = st.mwr;
  assign mem_byte_en    = st.ben;
  assign mem_wdata      = st.wdata;

  // Status.
  assign word_mode      = wide;
  assign illegal_access = st.illegal;
endmodule // hbw_adapter
`default_nettype wire

/* verif/hbw_adapter_properties.sv */
// Checker for the host bus width adapter ports.
`timescale 1ns/100ps
`default_nettype none
module hbw_adapter_chk #(parameter int ADDR_W = 13) (
  input wire logic clk, reset, width_sel, host_rd, host_wr,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [15:0] host_wdata, host_rdata, mem_wdata, mem_rdata,
  input wire logic [1:0] host_rdata_oe, mem_byte_en,
  input wire logic [ADDR_W-2:0] mem_addr,
  input wire logic mem_rd, mem_wr, word_mode, illegal_access);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire req = host_rd | host_wr;
  sequence rd_s(bit o, bit w);
    host_rd && !host_wr && host_addr[0] == o && word_mode == w ##1 1;
  endsequence
  ill_drop_a: assert property (req && host_addr[0] && word_mode |=> illegal_access
    && !mem_rd && !mem_wr) else $error("illegal request not dropped");
  word_wr_a: assert property (host_wr && !host_addr[0] && word_mode |=> mem_wr
    && mem_byte_en == 2'h3 && mem_wdata == $past(host_wdata)) else $error("word write");
  even_wr_a: assert property (host_wr && !host_addr[0] && !word_mode |=> mem_wr
    && mem_byte_en == 2'h1 && mem_wdata[7:0] == $past(host_wdata[7:0])) else $error("even");
  odd_wr_a: assert property (host_wr && host_addr[0] && !word_mode |=> mem_wr
    && mem_byte_en == 2'h2 && mem_wdata[15:8] == $past(host_wdata[7:0])) else $error("odd");
  addr_map_a: assert property (req && !(host_addr[0] && word_mode) |=>
    mem_addr == $past(host_addr[ADDR_W-1:1])) else $error("word address wrong");
  odd_rd_a: assert property (rd_s(1, 0) |=> host_rdata_oe == 2'h1
    && host_rdata == {8'hFF, $past(mem_rdata[15:8])}) else $error("odd read");
  even_rd_a: assert property (rd_s(0, 0) |=> host_rdata_oe == 2'h1
    && host_rdata == {8'hFF, $past(mem_rdata[7:0])}) else $error("even read");
  word_rd_a: assert property (rd_s(0, 1) |=> host_rdata_oe == 2'h3
    && host_rdata == $past(mem_rdata)) else $error("word read");
  mode_a: assert property ($stable(width_sel)[*6] |-> word_mode == width_sel)
    else $error("mode does not follow strap");
endmodule // hbw_adapter_chk
bind hbw_adapter hbw_adapter_chk #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

/* verif/hbw_store_model.sv */
// Word store model behind the adapter.
`timescale 1ns/100ps
`default_nettype none
module hbw_store_model (
  input wire logic clk, mem_rd, mem_wr,
  input wire logic [11:0] mem_addr,
  input wire logic [1:0] mem_byte_en,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata);
  logic [15:0] m [4096];
  logic [15:0] junk = 16'h5AA5;
  initial begin
    foreach (m[i]) m[i] = 16'h0;
  end
  // The store answers while its read strobe stands; off a read it shows junk that
  // moves every cycle, so a sample taken at the wrong edge is caught.
  assign mem_rdata = mem_rd ? m[mem_addr] : junk;
  always @(posedge clk) begin
    junk <= junk + 16'h3C5B;
    if (mem_wr && mem_byte_en[0]) m[mem_addr][7:0] <= mem_wdata[7:0];
    if (mem_wr && mem_byte_en[1]) m[mem_addr][15:8] <= mem_wdata[15:8];
  end
endmodule // hbw_store_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the host bus width adapter.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, reset = 1, width_sel = 0, host_rd = 0, host_wr = 0;
  logic mem_rd, mem_wr, word_mode, illegal_access;
  logic [12:0] host_addr = 0;
  logic [15:0] host_wdata = 0, host_rdata, mem_wdata, mem_rdata;
  logic [1:0] host_rdata_oe, mem_byte_en;
  logic [11:0] mem_addr;
  logic [15:0] ref_m [4096];
  logic [31:0] seed = 73212, r;
  int fails = 0, check_count = 0;
  always #10 clk = ~clk;
  hbw_adapter uut (.clk, .reset, .width_sel, .host_rd, .host_wr, .host_addr, .host_wdata,
    .host_rdata, .host_rdata_oe, .mem_addr, .mem_rd, .mem_wr, .mem_byte_en, .mem_wdata,
    .mem_rdata, .word_mode, .illegal_access);
  hbw_store_model mdl (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_byte_en, .mem_wdata,
    .mem_rdata);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [15:0] got, logic [15:0] ex);
    check_count++;
    if (got !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [15:0] exp_rd(logic wm, logic a0, logic [15:0] x);
    return wm ? x : {8'hFF, a0 ? x[15:8] : x[7:0]};
  endfunction
  // Result and lane drive stand in the cycle after the store is read, so look there.
  task automatic op(logic w, logic [12:0] a, logic [15:0] d);
    logic wm;
    logic [15:0] x;
    wm = word_mode;
    x = ref_m[a[12:1]];
    host_wr = w;
    host_rd = !w;
    host_addr = a;
    host_wdata = d;
    @(negedge clk);
    host_wr = 0;
    host_rd = 0;
    @(negedge clk);
    chk("illegal", {15'h0, illegal_access}, {15'h0, wm && a[0]});
    if (!w && !(wm && a[0])) begin
      chk("rdata", host_rdata, exp_rd(wm, a[0], x));
      chk("oe", {14'h0, host_rdata_oe}, wm ? 16'h3 : 16'h1);
    end
    if (w && wm && !a[0]) ref_m[a[12:1]] = d;
    else if (w && !wm && a[0]) ref_m[a[12:1]][15:8] = d[7:0];
    else if (w && !wm) ref_m[a[12:1]][7:0] = d[7:0];
  endtask
  initial begin
    foreach (ref_m[i]) ref_m[i] = 16'h0;
    repeat (8) @(negedge clk);
    reset = 0;
    for (int m = 0; m < 2; m++) begin
      width_sel = m[0];
      repeat (8) @(negedge clk);
      chk("mode", {15'h0, word_mode}, {15'h0, m[0]});
      op(1, 13'h1FFE, 16'h3CC3);
      op(1, 13'h1FFF, 16'hA55A);
      op(0, 13'h1FFE, 16'h0);
      for (int i = 0; i < 200; i++) begin
        r = rnd();
        op(r[31], {8'h0, r[4:0]}, r[23:8]);
      end
      // A host with 16-bit cycles only grounds the byte bit and shifts its word address by one.
      for (int i = 0; i < 16 && m == 1; i++) begin
        r = rnd();
        op(r[31], {r[13:2], 1'h0}, r[23:8]);
      end
      $display("test mode %0d done", m);
    end
    final_report();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
